// File: design/ofd_consts.vh
// Constants for the output fault and diagnostic parameter block
`ifndef OFD_CONSTS_VH
`define OFD_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFD_REG_UNIT_CFG   12'h000
`define OFD_REG_OC_EN      12'h004
`define OFD_REG_FAULT_MODE 12'h008
`define OFD_REG_IDLE_MD    12'h00C
`define OFD_REG_OUT_CMD    12'h010
`define OFD_REG_STATUS     12'h014
`define OFD_REG_IRQ_EN     12'h018
`define OFD_REG_IRQ_CLR    12'h01C
`define OFD_REG_OC_ERR     12'h020
`define OFD_REG_OUT_STATE  12'h024
`define OFD_REG_LINK       12'h028

// ----------------------------------------------------------------
// Unit configuration fields
// ----------------------------------------------------------------
`define OFD_CFG_CTRL_MON   0
`define OFD_CFG_OUT_MON    1
`define OFD_CFG_SC_EN      2
`define OFD_CFG_SC_MANUAL  3
`define OFD_CFG_RESET      4'h4

// ----------------------------------------------------------------
// Output substitution modes, two bits per channel
// ----------------------------------------------------------------
`define OFD_MODE_CLEAR     2'h0
`define OFD_MODE_HOLD      2'h1
`define OFD_MODE_FORCE_ON  2'h2

// ----------------------------------------------------------------
// Status and interrupt bits
// ----------------------------------------------------------------
`define OFD_ST_CTRL_SUP    0
`define OFD_ST_OUT_SUP     1
`define OFD_ST_SHORT       2
`define OFD_ST_OPEN        3
`define OFD_ST_FAULT       4
`define OFD_ST_RELOAD      5
`define OFD_ST_W           6

`endif

// File: design/ofd_top.v
// Output fault, diagnostic and parameter-source logic with APB registers
//
// Contract
// R1 - With the control supply monitor on, a control supply above 29 V or below 18 V flags an error.
// R2 - With the output supply monitor on, an output supply above 29 V or below 19 V flags an error.
// R3 - Any monitor or detection switched off suppresses its error.
// R4 - Valve short detection, on by default, flags an error on a valve short.
// R5 - In automatic recovery, the default, the short error clears as soon as the short is gone.
// R6 - In manual recovery the short error stays latched until a fresh power-up; the code also clears the latch when manual mode is left.
// R7 - Open-circuit detection, off by default, flags a per-channel error for a lost valve.
// R8 - On a communication fault each channel follows its fault mode: off, hold or forced on.
// R9 - Forced on drives the channel high whatever was commanded while the fault lasts.
// R10 - During communication idle the default idle mode turns each channel off.
// R11 - Whatever idle mode the terminal picks, outputs stay off while the link is idle.
// R12 - Settings are held per unit and per channel and are writable by controller or terminal.
// R13 - A terminal write changes only the active copy, never the controller's stored copy.
// R14 - After link loss and return the controller copy replaces terminal changes.
// R15 - When normal communication resumes outputs follow the controller command again.
//
// Chosen here: the address map and the APB interface to the registers.
module ofd_top #(
  parameter CH_N = 16
) (
  // Clock and reset
  input  wire              sys_clk_i,
  input  wire              reset_n_i,
  // APB slave (controller side)
  input  wire              psel_i,
  input  wire              penable_i,
  input  wire              pwrite_i,
  input  wire [11:0]       paddr_i,
  input  wire [31:0]       pwdata_i,
  output wire              pready_o,
  output wire              pslverr_o,
  output reg  [31:0]       prdata_o,
  // Handheld terminal writes, same register layout
  input  wire              ht_wr_i,
  input  wire [11:0]       ht_addr_i,
  input  wire [31:0]       ht_wdata_i,
  // Link state (same clock domain)
  input  wire              link_up_i,
  input  wire              comm_fault_i,
  input  wire              comm_idle_i,
  // Sensor flags from pins
  input  wire              ctrl_sup_high_i,
  input  wire              ctrl_sup_low_i,
  input  wire              out_sup_high_i,
  input  wire              out_sup_low_i,
  input  wire              valve_short_i,
  input  wire [CH_N-1:0]   valve_open_i,
  // Outputs
  output reg  [CH_N-1:0]   valve_out_o,
  output wire              ctrl_sup_err_o,
  output wire              out_sup_err_o,
  output wire              short_err_o,
  output wire [CH_N-1:0]   open_err_o,
  output wire              irq_o
);

`include "ofd_consts.vh"

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam SW = 5 + CH_N;
  reg  [SW-1:0] sync1_q;
  reg  [SW-1:0] sync2_q;
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      sync1_q <= {SW{1'b0}};
      sync2_q <= {SW{1'b0}};
    end else begin
      sync1_q <= {valve_open_i, valve_short_i, out_sup_low_i, out_sup_high_i,
                  ctrl_sup_low_i, ctrl_sup_high_i};
      sync2_q <= sync1_q;
    end
  end
  wire            c_hi    = sync2_q[0];
  wire            c_lo    = sync2_q[1];
  wire            o_hi    = sync2_q[2];
  wire            o_lo    = sync2_q[3];
  wire            sc_pin  = sync2_q[4];
  wire [CH_N-1:0] oc_pin  = sync2_q[SW-1:5];

  // ----------------------------------------------------------------
  // Parameter copies: controller-stored and active
  // ----------------------------------------------------------------
  reg  [3:0]        plc_cfg_q;
  reg  [CH_N-1:0]   plc_oc_q;
  reg  [2*CH_N-1:0] plc_fmd_q;
  reg  [2*CH_N-1:0] plc_imd_q;
  reg  [3:0]        act_cfg_q;
  reg  [CH_N-1:0]   act_oc_q;
  reg  [2*CH_N-1:0] act_fmd_q;
  reg  [2*CH_N-1:0] act_imd_q;
  reg  [CH_N-1:0]   cmd_q;
  reg  [CH_N-1:0]   held_q;
  reg  [CH_N-1:0]   irq_en_q;
  reg  [`OFD_ST_W-1:0] status_q;
  reg               link_q;
  reg               sc_latch_q;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  wire apb_wr = psel_i & penable_i & pwrite_i;
  wire apb_rd = psel_i & penable_i & ~pwrite_i;
  wire link_back = link_up_i & ~link_q;

  wire a_cfg  = (paddr_i == `OFD_REG_UNIT_CFG);
  wire a_oc   = (paddr_i == `OFD_REG_OC_EN);
  wire a_fmd  = (paddr_i == `OFD_REG_FAULT_MODE);
  wire a_imd  = (paddr_i == `OFD_REG_IDLE_MD);
  wire h_cfg  = (ht_addr_i == `OFD_REG_UNIT_CFG);
  wire h_oc   = (ht_addr_i == `OFD_REG_OC_EN);
  wire h_fmd  = (ht_addr_i == `OFD_REG_FAULT_MODE);
  wire h_imd  = (ht_addr_i == `OFD_REG_IDLE_MD);

  // ----------------------------------------------------------------
  // Controller copy
  // ----------------------------------------------------------------
  // Only the bus writes it, so terminal edits never leak back
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      plc_cfg_q <= `OFD_CFG_RESET;
      plc_oc_q  <= {CH_N{1'b0}};
      plc_fmd_q <= {2*CH_N{1'b0}};
      plc_imd_q <= {2*CH_N{1'b0}};
      cmd_q     <= {CH_N{1'b0}};
      irq_en_q  <= {CH_N{1'b0}};
      link_q    <= 1'b0;
    end else begin
      link_q <= link_up_i;
      if (apb_wr && a_cfg) begin
        plc_cfg_q <= pwdata_i[3:0]; // [R13]
      end
      if (apb_wr && a_oc) begin
        plc_oc_q <= pwdata_i[CH_N-1:0];
      end
      if (apb_wr && a_fmd) begin
        plc_fmd_q <= pwdata_i[2*CH_N-1:0];
      end
      if (apb_wr && a_imd) begin
        plc_imd_q <= pwdata_i[2*CH_N-1:0];
      end
      if (apb_wr && (paddr_i == `OFD_REG_OUT_CMD)) begin
        cmd_q <= pwdata_i[CH_N-1:0];
      end
      if (apb_wr && (paddr_i == `OFD_REG_IRQ_EN)) begin
        irq_en_q <= pwdata_i[CH_N-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Active copy
  // ----------------------------------------------------------------
  // Bus wins over terminal on a same-cycle collision; a link return
  // reloads the controller copy over both, as that copy is the reference
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      act_cfg_q <= `OFD_CFG_RESET;
      act_oc_q  <= {CH_N{1'b0}};
      act_fmd_q <= {2*CH_N{1'b0}};
      act_imd_q <= {2*CH_N{1'b0}};
    end else if (link_back) begin
      act_cfg_q <= plc_cfg_q; // [R14]
      act_oc_q  <= plc_oc_q;
      act_fmd_q <= plc_fmd_q;
      act_imd_q <= plc_imd_q;
    end else begin
      if (apb_wr && a_cfg) begin
        act_cfg_q <= pwdata_i[3:0]; // [R12]
      end else if (ht_wr_i && h_cfg) begin
        act_cfg_q <= ht_wdata_i[3:0]; // [R12] [R13]
      end
      if (apb_wr && a_oc) begin
        act_oc_q <= pwdata_i[CH_N-1:0];
      end else if (ht_wr_i && h_oc) begin
        act_oc_q <= ht_wdata_i[CH_N-1:0];
      end
      if (apb_wr && a_fmd) begin
        act_fmd_q <= pwdata_i[2*CH_N-1:0];
      end else if (ht_wr_i && h_fmd) begin
        act_fmd_q <= ht_wdata_i[2*CH_N-1:0];
      end
      if (apb_wr && a_imd) begin
        act_imd_q <= pwdata_i[2*CH_N-1:0];
      end else if (ht_wr_i && h_imd) begin
        act_imd_q <= ht_wdata_i[2*CH_N-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Diagnostics
  // ----------------------------------------------------------------
  wire ctrl_supply_monitor_en = act_cfg_q[`OFD_CFG_CTRL_MON];
  wire out_supply_monitor_en  = act_cfg_q[`OFD_CFG_OUT_MON];
  wire valve_short_detect_en  = act_cfg_q[`OFD_CFG_SC_EN];
  wire short_recovery_mode    = act_cfg_q[`OFD_CFG_SC_MANUAL];

  assign ctrl_sup_err_o = ctrl_supply_monitor_en & (c_hi | c_lo); // [R1] [R3]
  assign out_sup_err_o  = out_supply_monitor_en & (o_hi | o_lo); // [R2] [R3]
  assign open_err_o     = act_oc_q & oc_pin; // [R7] [R3]

  // ----------------------------------------------------------------
  // Short-circuit recovery
  // ----------------------------------------------------------------
  // In manual mode the latch only clears with reset, which stands for power-up;
  // leaving manual mode drops it, as automatic recovery then applies
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      sc_latch_q <= 1'b0;
    end else if (valve_short_detect_en && sc_pin && short_recovery_mode) begin
      sc_latch_q <= 1'b1; // [R6]
    end else if (!short_recovery_mode) begin
      sc_latch_q <= 1'b0;
    end
  end
  assign short_err_o = valve_short_detect_en & (sc_pin | sc_latch_q); // [R4] [R5] [R3]

  // ----------------------------------------------------------------
  // Output substitution
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < CH_N; g = g + 1) begin : g_ch
      // Held value only follows normal traffic, so a fault replays the last good command
      wire [1:0] comm_fault_output_mode = act_fmd_q[2*g+1:2*g];
      always @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
          valve_out_o[g] <= 1'b0;
          held_q[g]      <= 1'b0;
        end else if (comm_fault_i) begin
          if (comm_fault_output_mode == `OFD_MODE_FORCE_ON) begin
            valve_out_o[g] <= 1'b1; // [R9] [R8]
          end else if (comm_fault_output_mode == `OFD_MODE_HOLD) begin
            valve_out_o[g] <= held_q[g]; // [R8]
          end else begin
            valve_out_o[g] <= 1'b0; // [R8]
          end
        end else if (comm_idle_i) begin
          // Idle mode register is stored but ignored by design
          valve_out_o[g] <= 1'b0; // [R10] [R11]
        end else begin
          valve_out_o[g] <= cmd_q[g]; // [R15]
          held_q[g]      <= cmd_q[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Sticky status and interrupt
  // ----------------------------------------------------------------
  wire [`OFD_ST_W-1:0] ev = {link_back, comm_fault_i, |open_err_o, short_err_o,
                             out_sup_err_o, ctrl_sup_err_o};
  wire [`OFD_ST_W-1:0] clr = (apb_wr && (paddr_i == `OFD_REG_IRQ_CLR)) ?
                             pwdata_i[`OFD_ST_W-1:0] : {`OFD_ST_W{1'b0}};
  // Set wins over a same-cycle clear so no event is lost
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      status_q <= {`OFD_ST_W{1'b0}};
    end else begin
      status_q <= (status_q & ~clr) | ev;
    end
  end
  assign irq_o = |(status_q & irq_en_q[`OFD_ST_W-1:0]);

  // ----------------------------------------------------------------
  // APB read path
  // ----------------------------------------------------------------
  // Zero wait states: every access completes in its first access cycle
  assign pready_o  = 1'b1;
  assign pslverr_o = 1'b0;
  // Unmapped and write-only offsets read as zero
  always @* begin
    prdata_o = 32'h0000_0000;
    if (apb_rd) begin
      if (a_cfg) begin
        prdata_o[3:0] = act_cfg_q;
      end else if (a_oc) begin
        prdata_o[CH_N-1:0] = act_oc_q;
      end else if (a_fmd) begin
        prdata_o[2*CH_N-1:0] = act_fmd_q;
      end else if (a_imd) begin
        prdata_o[2*CH_N-1:0] = act_imd_q;
      end else if (paddr_i == `OFD_REG_OUT_CMD) begin
        prdata_o[CH_N-1:0] = cmd_q;
      end else if (paddr_i == `OFD_REG_STATUS) begin
        prdata_o[`OFD_ST_W-1:0] = status_q;
      end else if (paddr_i == `OFD_REG_IRQ_EN) begin
        prdata_o[CH_N-1:0] = irq_en_q;
      end else if (paddr_i == `OFD_REG_OC_ERR) begin
        prdata_o[CH_N-1:0] = open_err_o;
      end else if (paddr_i == `OFD_REG_OUT_STATE) begin
        prdata_o[CH_N-1:0] = valve_out_o;
      end else if (paddr_i == `OFD_REG_LINK) begin
        prdata_o[2:0] = {comm_idle_i, comm_fault_i, link_up_i};
      end
    end
  end

endmodule

// File: testbench/ofd_chk_assertions.sv
// Port-level concurrent checks for the output fault and diagnostic block
module ofd_chk #(
  parameter int CH_N = 16
) (
  input wire logic            sys_clk_i,
  input wire logic            reset_n_i,
  input wire logic            psel_i,
  input wire logic            penable_i,
  input wire logic            pwrite_i,
  input wire logic [11:0]     paddr_i,
  input wire logic [31:0]     pwdata_i,
  input wire logic            pready_o,
  input wire logic            pslverr_o,
  input wire logic [31:0]     prdata_o,
  input wire logic            comm_fault_i,
  input wire logic            comm_idle_i,
  input wire logic            ctrl_sup_high_i,
  input wire logic            ctrl_sup_low_i,
  input wire logic            out_sup_high_i,
  input wire logic            out_sup_low_i,
  input wire logic [CH_N-1:0] valve_open_i,
  input wire logic [CH_N-1:0] valve_out_o,
  input wire logic            ctrl_sup_err_o,
  input wire logic            out_sup_err_o,
  input wire logic [CH_N-1:0] open_err_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // ---------------------------------------------
  // Command write then a normal-link cycle
  // ---------------------------------------------
  sequence s_cmd_wr;
    psel_i && penable_i && pwrite_i && paddr_i == 12'h010 && !comm_fault_i && !comm_idle_i;
  endsequence
  sequence s_run;
    !comm_fault_i && !comm_idle_i;
  endsequence
  AST_ZERO_WAIT: assert property (pready_o && !pslverr_o)
    else $error("slave stalled or flagged an error");
  AST_RDATA_IDLE: assert property (!(psel_i && penable_i) |-> prdata_o == 32'h0)
    else $error("read data not zero outside access");
  AST_CLR_READS_ZERO: assert property (psel_i && penable_i && !pwrite_i &&
    paddr_i == 12'h01C |-> prdata_o == 32'h0) else $error("clear register read not zero");
  AST_UNMAPPED_ZERO: assert property (psel_i && penable_i && !pwrite_i &&
    paddr_i > 12'h028 |-> prdata_o == 32'h0) else $error("unmapped read not zero");
  AST_IDLE_OFF: assert property (comm_idle_i && !comm_fault_i |=> valve_out_o == '0)
    else $error("output on while link idle");
  AST_CTRL_QUIET: assert property (!ctrl_sup_high_i && !ctrl_sup_low_i |-> ##2 !ctrl_sup_err_o)
    else $error("control supply error without cause");
  AST_OUT_QUIET: assert property (!out_sup_high_i && !out_sup_low_i |-> ##2 !out_sup_err_o)
    else $error("output supply error without cause");
  AST_OPEN_QUIET: assert property (valve_open_i == '0 |-> ##2 open_err_o == '0)
    else $error("open error without a lost valve");
  AST_CMD_FOLLOW: assert property (s_cmd_wr ##1 s_run |=>
    valve_out_o == $past(pwdata_i[CH_N-1:0], 2)) else $error("outputs ignore command");
endmodule

bind ofd_top ofd_chk #(.CH_N(CH_N)) u_ofd_chk (.sys_clk_i, .reset_n_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .pslverr_o, .prdata_o, .comm_fault_i,
  .comm_idle_i, .ctrl_sup_high_i, .ctrl_sup_low_i, .out_sup_high_i, .out_sup_low_i,
  .valve_open_i, .valve_out_o, .ctrl_sup_err_o, .out_sup_err_o, .open_err_o);

// File: testbench/ofd_plc_model.sv
// Controller link model: connection, fault and idle levels
module ofd_plc_model (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       reset_n_i,
  // Scenario: 0 down, 1 run, 2 fault, 3 idle
  input  wire logic [1:0] mode_i,
  // Link state
  output logic            link_up_o,
  output logic            comm_fault_o,
  output logic            comm_idle_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Reconnect after a drop makes the device reload our settings
  always @(posedge sys_clk_i) begin
    link_up_o <= reset_n_i && mode_i != 2'h0;
    comm_fault_o <= reset_n_i && mode_i == 2'h2;
    comm_idle_o <= reset_n_i && mode_i == 2'h3;
  end
endmodule

// File: testbench/test_output_fault_diag_param_logic.sv
// Self-checking bench for the output fault and diagnostic block
`include "ofd_consts.vh"
module test_output_fault_diag_param_logic;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk_i = 1'h0;
  logic        reset_n_i = 1'h0;
  logic        psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0, ht_wr_i = 1'h0;
  logic [11:0] paddr_i = 12'h000, ht_addr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, ht_wdata_i = 32'h0, rd;
  logic        ctrl_sup_high_i = 1'h0, ctrl_sup_low_i = 1'h0, valve_short_i = 1'h0;
  logic        out_sup_high_i = 1'h0, out_sup_low_i = 1'h0;
  logic [15:0] valve_open_i = 16'h0000;
  logic [1:0]  link_mode = 2'h0;
  wire         pready_o, pslverr_o, link_up_i, comm_fault_i, comm_idle_i;
  wire         ctrl_sup_err_o, out_sup_err_o, short_err_o, irq_o;
  wire  [31:0] prdata_o;
  wire  [15:0] valve_out_o, open_err_o;
  int          mismatches = 0;
  int          comparisons = 0;
  ofd_top #(.CH_N(16)) u_ofd_top (.sys_clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .pready_o, .pslverr_o, .prdata_o, .ht_wr_i, .ht_addr_i,
    .ht_wdata_i, .link_up_i, .comm_fault_i, .comm_idle_i, .ctrl_sup_high_i, .ctrl_sup_low_i,
    .out_sup_high_i, .out_sup_low_i, .valve_short_i, .valve_open_i, .valve_out_o,
    .ctrl_sup_err_o, .out_sup_err_o, .short_err_o, .open_err_o, .irq_o);
  ofd_plc_model u_ofd_plc_model (.sys_clk_i, .reset_n_i, .mode_i(link_mode),
    .link_up_o(link_up_i), .comm_fault_o(comm_fault_i), .comm_idle_o(comm_idle_i));
  always #20 sys_clk_i = ~sys_clk_i;
  // ---------------------------------------------
  // Tasks
  // ---------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel_i <= 1'h1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'h1;
    do @(posedge sys_clk_i); while (pready_o !== 1'h1);
    rd = prdata_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    cmp(rd, e);
  endtask
  // Terminal writes are single-cycle pulses
  task automatic ht(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    ht_wr_i <= 1'h1;
    ht_addr_i <= a;
    ht_wdata_i <= d;
    @(posedge sys_clk_i);
    ht_wr_i <= 1'h0;
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ---------------------------------------------
  // Tests
  // ---------------------------------------------
  initial begin
    cyc(4);
    reset_n_i <= 1'h1;
    link_mode <= 2'h1;
    rdc(`OFD_REG_UNIT_CFG, 32'h4);
    rdc(`OFD_REG_OC_EN, 32'h0);
    rdc(`OFD_REG_FAULT_MODE, 32'h0);
    apb(1'h1, 12'h100, 32'hFFFFFFFF);
    rdc(12'h100, 32'h0);
    rdc(`OFD_REG_IRQ_CLR, 32'h0);
    $display("Reset values done");
    ctrl_sup_high_i <= 1'h1;
    out_sup_low_i <= 1'h1;
    cyc(4);
    cmp({ctrl_sup_err_o, out_sup_err_o}, 32'h0);
    apb(1'h1, `OFD_REG_IRQ_EN, 32'h3);
    apb(1'h1, `OFD_REG_UNIT_CFG, 32'h7);
    cyc(2);
    cmp({ctrl_sup_err_o, out_sup_err_o, irq_o}, 32'h7);
    {ctrl_sup_high_i, ctrl_sup_low_i, out_sup_high_i, out_sup_low_i} <= 4'h6;
    cyc(4);
    cmp({ctrl_sup_err_o, out_sup_err_o}, 32'h3);
    {ctrl_sup_low_i, out_sup_high_i} <= 2'h0;
    cyc(4);
    cmp({ctrl_sup_err_o, out_sup_err_o, irq_o}, 32'h1);
    apb(1'h1, `OFD_REG_IRQ_CLR, 32'h3);
    apb(1'h1, `OFD_REG_IRQ_EN, 32'h0);
    ctrl_sup_low_i <= 1'h1;
    cyc(4);
    cmp(irq_o, 32'h0);
    // Link reload bit stays set from the first connection after reset
    rdc(`OFD_REG_STATUS, 32'h21);
    ctrl_sup_low_i <= 1'h0;
    $display("Supply monitors done");
    valve_short_i <= 1'h1;
    cyc(4);
    cmp(short_err_o, 32'h1);
    valve_short_i <= 1'h0;
    cyc(4);
    cmp(short_err_o, 32'h0);
    apb(1'h1, `OFD_REG_UNIT_CFG, 32'hC);
    valve_short_i <= 1'h1;
    cyc(4);
    valve_short_i <= 1'h0;
    cyc(8);
    cmp(short_err_o, 32'h1);
    apb(1'h1, `OFD_REG_UNIT_CFG, 32'h8);
    valve_short_i <= 1'h1;
    cyc(4);
    cmp(short_err_o, 32'h0);
    valve_short_i <= 1'h0;
    valve_open_i <= 16'h8001;
    cyc(4);
    cmp(open_err_o, 32'h0);
    apb(1'h1, `OFD_REG_OC_EN, 32'hFFFF);
    cyc(1);
    cmp(open_err_o, 32'h8001);
    valve_open_i <= 16'h0000;
    $display("Detection done");
    apb(1'h1, `OFD_REG_OUT_CMD, 32'hA5A5);
    cyc(2);
    cmp(valve_out_o, 32'hA5A5);
    // Groups of four: clear, hold, force on, code 3
    apb(1'h1, `OFD_REG_FAULT_MODE, 32'hFFAA5500);
    link_mode <= 2'h2;
    cyc(3);
    cmp(valve_out_o, 32'h0FA0);
    apb(1'h1, `OFD_REG_OUT_CMD, 32'h5A5A);
    cyc(2);
    cmp(valve_out_o, 32'h0FA0);
    link_mode <= 2'h1;
    cyc(3);
    cmp(valve_out_o, 32'h5A5A);
    ht(`OFD_REG_IDLE_MD, 32'hAAAAAAAA);
    link_mode <= 2'h3;
    cyc(3);
    cmp(valve_out_o, 32'h0);
    link_mode <= 2'h1;
    cyc(3);
    cmp(valve_out_o, 32'h5A5A);
    $display("Output substitution done");
    ht(`OFD_REG_OC_EN, 32'h00FF);
    rdc(`OFD_REG_OC_EN, 32'h00FF);
    link_mode <= 2'h0;
    cyc(3);
    link_mode <= 2'h1;
    cyc(3);
    rdc(`OFD_REG_OC_EN, 32'hFFFF);
    rdc(`OFD_REG_IDLE_MD, 32'h0);
    $display("Parameter source done");
    // Fresh power-up drops the manual short latch left from earlier
    reset_n_i <= 1'h0;
    cyc(4);
    reset_n_i <= 1'h1;
    apb(1'h1, `OFD_REG_UNIT_CFG, 32'hC);
    cyc(1);
    cmp(short_err_o, 32'h0);
    rdc(`OFD_REG_OC_EN, 32'h0);
    $display("Power-up reset done");
    tally_and_finish();
  end
  initial begin
    #400000;
    mismatches++;
    tally_and_finish();
  end
endmodule
